/* File: rtl/pmcs_power_mode.sv */
// Power-managed mode controller with clock source sequencing
// What this block does
// - CPU clocking follows the idle select bit and the source field picks primary, secondary or internal.
// - Sleep with idle clear and primary source stops all CPU and peripheral clocks.
// - Sleep with idle set stops the CPU clock and keeps peripherals clocked from the source.
// - Sleep with idle clear and a non-primary source keeps CPU and peripherals on that source.
// - An interrupt, reset or watchdog time-out returns any mode to primary full-power run.
// - In a reduced-clock run mode a watchdog time-out raises a watchdog reset.
// - Run modes can be left by another sleep into sleep or idle, or by a reset instruction.
// - In primary run the primary stable flag is set, the internal flag set when internal is primary.
// - Entering secondary run moves to the secondary clock, stops primary, sets active, clears stable.
// - A secondary-run sleep with the secondary oscillator disabled is ignored.
// - Clocks are held off until an enabled but not yet running secondary oscillator starts.
// - A wake in secondary run stays on secondary until primary is ready, then swaps the flags.
// - Such a wake leaves idle select and source field alone and the secondary running.
// - Clearing the secondary enable in secondary run switches back, then stops the secondary.
// - Internal run clocks CPU and peripherals from the internal block.
`timescale 1ns/1ps
module pmcs_power_mode (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             sleep_exec,
    input  wire logic             reset_instr,
    input  wire logic             irq_wake,
    input  wire logic             ext_reset,
    input  wire logic             wdt_timeout,
    input  wire logic             cpu_gate_select,
    input  wire logic [1:0]       clock_source_select,
    input  wire logic             secondary_osc_enable,
    input  wire logic             secondary_osc_running,
    input  wire logic             primary_osc_ready,
    input  wire logic             internal_is_primary,
    input  wire logic             internal_osc_ready,
    output logic                  cpu_clk_en,
    output logic                  periph_clk_en,
    output logic                  pri_clk_sel,
    output logic                  sec_clk_sel,
    output logic                  int_clk_sel,
    output logic                  primary_osc_on,
    output logic                  secondary_osc_on,
    output logic                  primary_clock_stable_flag,
    output logic                  internal_osc_stable_flag,
    output logic                  secondary_clock_active_flag,
    output logic                  wdt_reset_req,
    output logic                  core_reset_req,
    output pmcs_pkg::pmcs_mode_t  mode
);
    import pmcs_pkg::*;

    // ---------------------------------------------------------------
    // Mode state
    // ---------------------------------------------------------------
    pmcs_mode_t mode_r;
    pmcs_mode_t mode_nxt;
    logic       sec_act_r;
    logic       sec_act_nxt;
    logic       pri_stb_r;
    logic       pri_stb_nxt;
    logic       sec_keep_r;
    logic       sec_keep_nxt;
    logic       wdt_rst_r;
    logic       core_rst_r;
    pmcs_clk_t  want_clk;
    pmcs_clk_t  cur_clk;
    logic       sw_busy;

    // Decode of the requested mode
    wire src_pri   = (clock_source_select == SRC_PRIMARY);
    wire src_sec   = (clock_source_select == SRC_SECONDARY);
    wire src_int   = clock_source_select[1];
    wire wake      = irq_wake || ext_reset || wdt_timeout;
    wire in_run    = (mode_r == PMCS_SECONDARY_RUN_MODE) || (mode_r == PMCS_INT_RUN);
    wire in_idle   = (mode_r == PMCS_PRIMARY_IDLE_MODE) || (mode_r == PMCS_SECONDARY_IDLE_MODE) || (mode_r == PMCS_INT_IDLE);
    wire cpu_runs  = (mode_r == PMCS_PRIMARY_RUN_MODE) || in_run || (mode_r == PMCS_SWITCHBACK);
    wire sec_block = src_sec && !cpu_gate_select && !secondary_osc_enable;
    wire sleep_ok  = sleep_exec && cpu_runs && (mode_r != PMCS_SWITCHBACK) && !sec_block;
    // Ready only while powered; power is held through secondary run so an enable clear cannot drop it
    wire sec_ready = secondary_osc_on && secondary_osc_running;

    // Target mode of an accepted sleep instruction
    pmcs_mode_t sleep_tgt;
    always_comb begin
        if (cpu_gate_select) begin
            sleep_tgt = src_pri ? PMCS_PRIMARY_IDLE_MODE : (src_sec ? PMCS_SECONDARY_IDLE_MODE : PMCS_INT_IDLE);
        end else if (src_pri) begin
            sleep_tgt = PMCS_SLEEP;
        end else begin
            sleep_tgt = src_int ? PMCS_INT_RUN : PMCS_SECONDARY_RUN_MODE;
        end
    end

    // ---------------------------------------------------------------
    // Mode transitions
    // ---------------------------------------------------------------
    always_comb begin
        mode_nxt     = mode_r;
        sec_act_nxt  = sec_act_r;
        pri_stb_nxt  = pri_stb_r;
        sec_keep_nxt = sec_keep_r;
        case (mode_r)
            PMCS_PRIMARY_RUN_MODE: begin
                if (sleep_ok) begin
                    mode_nxt = sleep_tgt;
                end
            end
            PMCS_SECONDARY_RUN_MODE, PMCS_SECONDARY_IDLE_MODE: begin
                if (wake || reset_instr) begin
                    mode_nxt = PMCS_SWITCHBACK;
                end else if (mode_r == PMCS_SECONDARY_RUN_MODE && !secondary_osc_enable) begin
                    mode_nxt     = PMCS_SWITCHBACK;
                    sec_keep_nxt = 1'b1;
                end else if (sleep_ok) begin
                    mode_nxt = sleep_tgt;
                    // Only a secondary idle target keeps the secondary active flag; any other target clears it
                    if (sleep_tgt != PMCS_SECONDARY_IDLE_MODE) begin
                        sec_act_nxt = 1'b0;
                    end
                end
            end
            PMCS_INT_RUN: begin
                if (wake || reset_instr) begin
                    mode_nxt = PMCS_SWITCHBACK;
                end else if (sleep_ok) begin
                    mode_nxt = sleep_tgt;
                end
            end
            PMCS_PRIMARY_IDLE_MODE, PMCS_INT_IDLE, PMCS_SLEEP: begin
                if (wake) begin
                    mode_nxt = PMCS_SWITCHBACK;
                end
            end
            PMCS_SWITCHBACK: begin
                // Only an active secondary source keeps the core alive until primary is granted
                if (primary_osc_ready && cur_clk == PMCS_CLK_PRI && !sw_busy) begin
                    mode_nxt     = PMCS_PRIMARY_RUN_MODE;
                    sec_act_nxt  = 1'b0;
                    pri_stb_nxt  = 1'b1;
                    sec_keep_nxt = 1'b0;
                end
            end
            default: begin
                mode_nxt = PMCS_PRIMARY_RUN_MODE;
            end
        endcase
        // Flag update the moment secondary run mode is entered, ahead of the clock switch
        if (mode_r != PMCS_SECONDARY_RUN_MODE && mode_nxt == PMCS_SECONDARY_RUN_MODE) begin
            sec_act_nxt = 1'b1;
            pri_stb_nxt = 1'b0;
        end
        if (mode_nxt == PMCS_SLEEP || (mode_r == PMCS_PRIMARY_RUN_MODE && mode_nxt == PMCS_INT_RUN)) begin
            pri_stb_nxt = 1'b0;
        end
    end

    // Short register bank; idle/source bits are ports and never touched
    always_ff @(posedge clk) begin
        if (!nrst) begin
            mode_r     <= PMCS_PRIMARY_RUN_MODE;
            sec_act_r  <= 1'b0;
            pri_stb_r  <= 1'b1;
            sec_keep_r <= 1'b0;
            wdt_rst_r  <= 1'b0;
            core_rst_r <= 1'b0;
        end else begin
            mode_r     <= mode_nxt;
            sec_act_r  <= sec_act_nxt;
            pri_stb_r  <= pri_stb_nxt;
            sec_keep_r <= sec_keep_nxt;
            wdt_rst_r  <= wdt_timeout && in_run;
            core_rst_r <= reset_instr && cpu_runs;
        end
    end

    // ---------------------------------------------------------------
    // Clock routing
    // ---------------------------------------------------------------
    wire sec_mode = (mode_r == PMCS_SECONDARY_RUN_MODE) || (mode_r == PMCS_SECONDARY_IDLE_MODE);
    wire int_mode = (mode_r == PMCS_INT_RUN) || (mode_r == PMCS_INT_IDLE);
    wire sb_from_sec = (mode_r == PMCS_SWITCHBACK) && sec_act_r;
    always_comb begin
        if (mode_r == PMCS_SLEEP) begin
            want_clk = PMCS_CLK_NONE;
        end else if ((sec_mode && sec_ready) || (sb_from_sec && !primary_osc_ready)) begin
            want_clk = PMCS_CLK_SEC;
        end else if (sec_mode) begin
            want_clk = PMCS_CLK_NONE;
        end else if (int_mode) begin
            want_clk = PMCS_CLK_INT;
        end else if (mode_r == PMCS_SWITCHBACK && !primary_osc_ready) begin
            want_clk = PMCS_CLK_NONE;
        end else begin
            want_clk = PMCS_CLK_PRI;
        end
    end

    pmcs_glitch_switch u_switch (
        .clk     (clk),
        .nrst    (nrst),
        .req_sel (want_clk),
        .pri_sel (pri_clk_sel),
        .sec_sel (sec_clk_sel),
        .int_sel (int_clk_sel),
        .cur_sel (cur_clk),
        .busy    (sw_busy)
    );

    // Gating of CPU and peripheral domains
    wire any_clk = (cur_clk != PMCS_CLK_NONE);
    assign cpu_clk_en    = any_clk && cpu_runs && !sw_busy;
    assign periph_clk_en = any_clk && (cpu_runs || in_idle) && !sw_busy;

    // Oscillator enables: primary off in secondary run, started on switchback
    assign primary_osc_on   = !(sec_mode && sec_act_r) && (mode_r != PMCS_SLEEP);
    // Secondary kept powered while it clocks the core, so no dead cycle on an enable clear
    assign secondary_osc_on = secondary_osc_enable || sec_keep_r || (mode_r == PMCS_SECONDARY_RUN_MODE);

    // Status flags
    assign primary_clock_stable_flag   = pri_stb_r;
    assign internal_osc_stable_flag    = internal_osc_ready && (int_mode || internal_is_primary);
    assign secondary_clock_active_flag = sec_act_r;
    assign wdt_reset_req               = wdt_rst_r;
    assign core_reset_req              = core_rst_r;
    assign mode                        = mode_r;
endmodule

/* File: rtl/pmcs_pkg.sv */
// Package: power mode controller constants and types
package pmcs_pkg;
    // Clock source select encodings
    localparam logic [1:0] SRC_PRIMARY   = 2'h0;
    localparam logic [1:0] SRC_SECONDARY = 2'h1;
    // Bit positions inside the secondary timer control byte
    localparam int SEC_ACTIVE_BIT = 6;
    localparam int SEC_ENABLE_BIT = 3;
    // Clock switch settle: length in cycles of the dead gap between sources
    localparam logic [1:0] SWITCH_GAP_CYCLES = 2'h2;
    // Mode encodings as seen on the status port
    typedef enum logic [2:0] {
        PMCS_PRIMARY_RUN_MODE,
        PMCS_SECONDARY_RUN_MODE,
        PMCS_INT_RUN,
        PMCS_PRIMARY_IDLE_MODE,
        PMCS_SECONDARY_IDLE_MODE,
        PMCS_INT_IDLE,
        PMCS_SLEEP,
        PMCS_SWITCHBACK
    } pmcs_mode_t;
    // Clock routing selections
    typedef enum logic [1:0] {
        PMCS_CLK_NONE,
        PMCS_CLK_PRI,
        PMCS_CLK_SEC,
        PMCS_CLK_INT
    } pmcs_clk_t;
endpackage

/* File: rtl/pmcs_glitch_switch.sv */
// Glitch-free clock source selector with a dead gap between sources
`timescale 1ns/1ps
module pmcs_glitch_switch (
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire pmcs_pkg::pmcs_clk_t req_sel,
    output logic                   pri_sel,
    output logic                   sec_sel,
    output logic                   int_sel,
    output pmcs_pkg::pmcs_clk_t    cur_sel,
    output logic                   busy
);
    import pmcs_pkg::*;

    // ---------------------------------------------------------------
    // Source hand-over state
    // ---------------------------------------------------------------
    pmcs_clk_t  cur_r;
    pmcs_clk_t  cur_nxt;
    logic [1:0] gap_r;
    logic [1:0] gap_nxt;
    wire        differs = (req_sel != cur_r);

    // Old source dropped first, new one granted after the gap: no runt pulse
    always_comb begin
        cur_nxt = cur_r;
        gap_nxt = gap_r;
        if (gap_r != 2'h0) begin
            gap_nxt = gap_r - 2'h1;
            if (gap_r == 2'h1) begin
                cur_nxt = req_sel;
            end
        end else if (differs) begin
            cur_nxt = PMCS_CLK_NONE;
            gap_nxt = SWITCH_GAP_CYCLES;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cur_r <= PMCS_CLK_PRI;
            gap_r <= 2'h0;
        end else begin
            cur_r <= cur_nxt;
            gap_r <= gap_nxt;
        end
    end

    // One-hot gate enables decoded from the cur_r flops
    assign pri_sel = (cur_r == PMCS_CLK_PRI);
    assign sec_sel = (cur_r == PMCS_CLK_SEC);
    assign int_sel = (cur_r == PMCS_CLK_INT);
    assign cur_sel = cur_r;
    assign busy    = differs || (gap_r != 2'h0);
endmodule

/* File: tb/pmcs_osc_model.sv */
// Oscillator model: start-up delays of the primary and secondary sources
`timescale 1ns/1ps
module pmcs_osc_model #(
    parameter int PRI_START = 20,
    parameter int SEC_START = 10
) (
    input  wire logic clk,
    input  wire logic primary_osc_on,
    input  wire logic secondary_osc_on,
    input  wire logic sec_hold,
    output logic      primary_osc_ready,
    output logic      secondary_osc_running,
    output logic      internal_osc_ready
);
    int pri_cnt = 0;
    int sec_cnt = 0;
    // Counts restart at shutdown so a stale ready never lingers
    always @(posedge clk) begin
        pri_cnt <= primary_osc_on ? pri_cnt + 1 : 0;
        sec_cnt <= (secondary_osc_on && !sec_hold) ? sec_cnt + 1 : 0;
    end
    assign primary_osc_ready     = pri_cnt >= PRI_START;
    assign secondary_osc_running = sec_cnt >= SEC_START;
    assign internal_osc_ready    = 1'b1;
endmodule

/* File: tb/pmcs_power_mode_sva.sv */
// Checker: assertions on the power mode controller ports
`timescale 1ns/1ps
module pmcs_power_mode_sva (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       sleep_exec,
    input wire logic       reset_instr,
    input wire logic       wdt_timeout,
    input wire logic       cpu_gate_select,
    input wire logic [1:0] clock_source_select,
    input wire logic       secondary_osc_enable,
    input wire logic       secondary_osc_running,
    input wire logic       primary_osc_ready,
    input wire logic       cpu_clk_en,
    input wire logic       periph_clk_en,
    input wire logic       pri_clk_sel,
    input wire logic       sec_clk_sel,
    input wire logic       int_clk_sel,
    input wire logic       secondary_osc_on,
    input wire logic       primary_clock_stable_flag,
    input wire logic       secondary_clock_active_flag,
    input wire logic       wdt_reset_req,
    input wire logic       core_reset_req,
    input wire pmcs_pkg::pmcs_mode_t mode
);
    import pmcs_pkg::*;

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Secondary-run request taken from primary run
    sequence sec_req_s;
        mode == PMCS_PRIMARY_RUN_MODE && sleep_exec && !cpu_gate_select && clock_source_select == SRC_SECONDARY;
    endsequence
    sequence sec_entered_s;
        mode == PMCS_SECONDARY_RUN_MODE && secondary_clock_active_flag && !primary_clock_stable_flag;
    endsequence
    sel_onehot_a: assert property ($onehot0({pri_clk_sel, sec_clk_sel, int_clk_sel}))
        else $error("two sources selected");
    sleep_gated_a: assert property (mode == PMCS_SLEEP |-> !cpu_clk_en && !periph_clk_en)
        else $error("clock in sleep");
    idle_cpu_off_a: assert property (mode inside {PMCS_PRIMARY_IDLE_MODE, PMCS_SECONDARY_IDLE_MODE, PMCS_INT_IDLE} |-> !cpu_clk_en)
        else $error("cpu clocked in idle");
    sec_entry_a: assert property (sec_req_s and secondary_osc_enable |=> sec_entered_s)
        else $error("bad entry");
    sec_refused_a: assert property (sec_req_s and !secondary_osc_enable |=> mode == PMCS_PRIMARY_RUN_MODE)
        else $error("not refused");
    sec_hold_a: assert property (mode == PMCS_SECONDARY_RUN_MODE && !secondary_osc_running |-> !cpu_clk_en && !periph_clk_en)
        else $error("clock before secondary runs");
    back_wait_a: assert property (mode == PMCS_SWITCHBACK && !primary_osc_ready |-> !pri_clk_sel)
        else $error("early swap");
    sec_exit_a: assert property (mode == PMCS_SECONDARY_RUN_MODE && !secondary_osc_enable |-> secondary_osc_on)
        else $error("sec off");
    pri_stable_a: assert property (mode == PMCS_PRIMARY_RUN_MODE |-> primary_clock_stable_flag)
        else $error("stable flag low");
    wdt_run_a: assert property (wdt_timeout && mode inside {PMCS_SECONDARY_RUN_MODE, PMCS_INT_RUN} |=> wdt_reset_req)
        else $error("no watchdog reset");
    rst_instr_a: assert property (reset_instr && mode inside {PMCS_SECONDARY_RUN_MODE, PMCS_INT_RUN} |=> core_reset_req)
        else $error("no core reset");
endmodule
bind pmcs_power_mode pmcs_power_mode_sva pmcs_power_mode_sva_inst (.*);

/* File: tb/power_mode_clock_switch_bench.sv */
// Testbench: power mode sequences against the oscillator model
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module power_mode_clock_switch_bench;
    import pmcs_pkg::*;
    logic       clk = 0, nrst = 0, sleep_exec = 0, reset_instr = 0, irq_wake = 0, ext_reset = 0, wdt_timeout = 0;
    logic       cpu_gate_select = 0, secondary_osc_enable = 1, internal_is_primary = 0, sec_hold = 0;
    logic [1:0] clock_source_select = 2'h0;
    logic       secondary_osc_running, primary_osc_ready, internal_osc_ready, cpu_clk_en, periph_clk_en;
    logic       pri_clk_sel, sec_clk_sel, int_clk_sel, primary_osc_on, secondary_osc_on, wdt_reset_req;
    logic       primary_clock_stable_flag, internal_osc_stable_flag, secondary_clock_active_flag, core_reset_req;
    pmcs_mode_t mode;
    int         miscompares = 0, total_checks = 0, k;
    pmcs_mode_t run_m[4]  = '{PMCS_SLEEP, PMCS_SECONDARY_RUN_MODE, PMCS_INT_RUN, PMCS_INT_RUN};
    pmcs_mode_t idle_m[4] = '{PMCS_PRIMARY_IDLE_MODE, PMCS_SECONDARY_IDLE_MODE, PMCS_INT_IDLE, PMCS_INT_IDLE};
    logic [2:0] sel_m[4]  = '{3'h0, 3'h2, 3'h4, 3'h4};
    pmcs_power_mode pmcs_power_mode_inst (.*);
    pmcs_osc_model pmcs_osc_model_inst (.*);
    always #50 clk = ~clk;
    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic do_sleep(input logic idle, input logic [1:0] src);
        cpu_gate_select = idle;
        clock_source_select = src;
        sleep_exec = 1;
        tick(1);
        sleep_exec = 0;
    endtask
    // Kind 0 interrupt, 1 external reset, 2 watchdog, 3 reset instruction
    task automatic pulse(input int kind);
        {reset_instr, wdt_timeout, ext_reset, irq_wake} = 4'h1 << kind;
        tick(1);
        {reset_instr, wdt_timeout, ext_reset, irq_wake} = 4'h0;
    endtask
    // Bounded wait; the primary start-up sets the real length
    task automatic wait_mode(input pmcs_mode_t m);
        for (int i = 0; i < 200 && mode !== m; i++) tick(1);
        `CHK("mode", m, mode)
    endtask
    task automatic stop_test;
        if (miscompares == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Watchdog: fires at 5000 cycles; the whole sequence needs well under that
    initial begin
        #(100 * 5000);
        miscompares++;
        stop_test();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        tick(3);
        nrst = 1;
        tick(30);
        `CHK("pri_stable", 1'b1, primary_clock_stable_flag)
        `CHK("pri_sel", 1'b1, pri_clk_sel)
        secondary_osc_enable = 0;
        do_sleep(0, 2'h1);
        tick(2);
        `CHK("refused", PMCS_PRIMARY_RUN_MODE, mode)
        secondary_osc_enable = 1;
        tick(12);
        // Every idle bit and source code, woken by each event in turn
        for (k = 0; k < 8; k++) begin
            do_sleep(k[0], 2'(k / 2));
            tick(8);
            `CHK("mode", k[0] ? idle_m[k / 2] : run_m[k / 2], mode)
            `CHK("cpu_en", !k[0] && k / 2 != 0, cpu_clk_en)
            `CHK("periph_en", k[0] || k / 2 != 0, periph_clk_en)
            `CHK("sel", (k == 1) ? 3'h1 : sel_m[k / 2], {int_clk_sel, sec_clk_sel, pri_clk_sel})
            `CHK("sec_flag_in", k == 2, secondary_clock_active_flag)
            `CHK("pri_on", k != 0 && k != 2, primary_osc_on)
            `CHK("int_flag", k >= 4, internal_osc_stable_flag)
            pulse(k % 3);
            `CHK("wdt_rst", k == 2, wdt_reset_req)
            wait_mode(PMCS_PRIMARY_RUN_MODE);
            `CHK("sel_back", 1'b1, pri_clk_sel)
            `CHK("sec_flag", 1'b0, secondary_clock_active_flag)
            if (k / 2 == 1) `CHK("sec_on", 1'b1, secondary_osc_on)
            tick(2);
        end
        do_sleep(0, 2'h1);
        tick(4);
        secondary_osc_enable = 0;
        wait_mode(PMCS_PRIMARY_RUN_MODE);
        `CHK("sec_off", 1'b0, secondary_osc_on)
        `CHK("stable", 1'b1, primary_clock_stable_flag)
        secondary_osc_enable = 1;
        tick(12);
        do_sleep(0, 2'h2);
        tick(8);
        do_sleep(1, 2'h2);
        tick(2);
        `CHK("run_to_idle", PMCS_INT_IDLE, mode)
        pulse(0);
        wait_mode(PMCS_PRIMARY_RUN_MODE);
        do_sleep(0, 2'h1);
        tick(8);
        pulse(3);
        `CHK("core_rst", 1'b1, core_reset_req)
        wait_mode(PMCS_PRIMARY_RUN_MODE);
        tick(12);
        sec_hold = 1;
        do_sleep(0, 2'h1);
        tick(4);
        `CHK("held_cpu", 1'b0, cpu_clk_en)
        sec_hold = 0;
        tick(15);
        `CHK("sec_cpu", 1'b1, cpu_clk_en)
        pulse(0);
        wait_mode(PMCS_PRIMARY_RUN_MODE);
        internal_is_primary = 1;
        tick(1);
        `CHK("int_pri", 1'b1, internal_osc_stable_flag)
        stop_test();
    end
endmodule
